// ===== rcl_regs.svh
// Purpose: Timing counts and setting field widths for the recloser block.
// Assumes: 100 MHz system clock; all recloser intervals counted in 100 ms ticks.
// Notes: Definitions only; included by bare name.
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

`define RCL_CLK_MHZ 100
`define RCL_TICK_MS 100
`define RCL_TICK_CYCLES (`RCL_TICK_MS * 1000 * `RCL_CLK_MHZ)
`define RCL_TICKS_PER_SEC 10
`define RCL_ATTEMPTS_MAX 4
`define RCL_TENTHS_W 12
`define RCL_SECS_W 10
`define RCL_TIMER_W 14
`define RCL_PIN_W 10

// Positions inside the synchronised pin vector
`define RCL_PIN_OPEN_3P 9
`define RCL_PIN_OPEN_A 8
`define RCL_PIN_OPEN_B 7
`define RCL_PIN_OPEN_C 6
`define RCL_PIN_EXT_1P 5
`define RCL_PIN_EXT_3P 4
`define RCL_PIN_HOLD 3
`define RCL_PIN_CANCEL 2
`define RCL_PIN_LOCKOUT 1
`define RCL_PIN_RESET 0

`endif

// ===== rcl_pkg.sv
// Purpose: Types shared by the recloser modules.
// Assumes: rcl_regs.svh supplies the widths.
// Notes: One-hot state codes are written out.
`default_nettype none
`include "rcl_regs.svh"
package rcl_pkg;
    typedef logic [`RCL_TENTHS_W-1:0] rcl_tenths_t;
    typedef logic [`RCL_TIMER_W-1:0] rcl_timer_t;

    typedef enum logic [2:0] {
        RCL_SRC_NONE = 3'h0,
        RCL_SRC_INTERNAL = 3'h1,
        RCL_SRC_EXTERNAL = 3'h2,
        RCL_SRC_BOTH = 3'h3,
        RCL_SRC_OFF = 3'h4
    } rcl_source_e;

    typedef enum logic [1:0] {
        RCL_PROG_SINGLE = 2'h0,
        RCL_PROG_THREE = 2'h1,
        RCL_PROG_MIXED = 2'h2
    } rcl_program_e;

    typedef enum logic [5:0] {
        RCL_ST_RESET = 6'h01,
        RCL_ST_DELAY = 6'h02,
        RCL_ST_HOLD = 6'h04,
        RCL_ST_CLOSE = 6'h08,
        RCL_ST_SETTLE = 6'h10,
        RCL_ST_LOCKOUT = 6'h20
    } rcl_state_e;
endpackage
`default_nettype wire

// ===== rcl_tick_if.sv
// Purpose: Timebase link between the sequencer and its tick generator.
// Assumes: Single clock domain.
// Notes: restart realigns the tick phase so intervals are whole ticks.
`default_nettype none
interface rcl_tick_if;
    logic restart;
    logic tick;
    modport src (input restart, output tick);
    modport snk (output restart, input tick);
endinterface
`default_nettype wire

// ===== rcl_timebase.sv
// Purpose: 100 ms tick generator with phase restart.
// Assumes: clk at 100 MHz, srst synchronous active high.
// Notes: TICK_CYCLES is a parameter so simulation can shorten it.
`default_nettype none
`include "rcl_regs.svh"
module rcl_timebase #(
    parameter int unsigned TICK_CYCLES = `RCL_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    rcl_tick_if.src tb
);
    logic [31:0] cnt_ff;
    logic tick_ff;

    if (TICK_CYCLES < 2) begin : g_chk
        $error("rcl_timebase: TICK_CYCLES must be at least 2");
    end

    // Free-running divider, restarted when an interval is loaded
    always_ff @(posedge clk) begin
        if (srst || tb.restart) begin
            cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == TICK_CYCLES - 1) begin
            cnt_ff <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    assign tb.tick = tick_ff;
endmodule // rcl_timebase
`default_nettype wire

// ===== rcl_recloser.sv
// Purpose: Breaker reclose sequencer: initiates, hold, cancel, lockout, reset.
// Assumes: Contact inputs are asynchronous pins; internal initiates share clk.
// Notes: Settings are static plain ports; intervals counted in 100 ms ticks.
`default_nettype none
`include "rcl_regs.svh"

// Summary of operation
// R01 - Breaker open from one contact (three-pole) or any of three (single-pole).
// R02 - Single-pole initiate starts single-pole sequence; external source supplies it.
// R03 - Three-pole initiate starts three-pole sequence; external source supplies it.
// R04 - With hold enabled, after delay wait up to hold interval for permit.
// R05 - No permit by end of hold interval: skip close, go to lockout.
// R06 - Hold polarity selectable: closed permits or open permits.
// R07 - Permit already present at reclose demand: close at once, no hold wait.
// R08 - Hold supervision covers every reclose attempt.
// R09 - In reset, initiates ignored while cancel asserted; stay in reset.
// R10 - Cancel during active cycle outside close pulse goes to lockout.
// R11 - Cancel during close pulse: finish pulse, then lockout.
// R12 - Cancel has no effect in lockout.
// R13 - Lockout input forces lockout at once and holds it there.
// R14 - Lockout input released: reset if breaker closed, else stay locked out.
// R15 - Reset input leaves lockout for reset only with breaker closed.
// R16 - Close output lasts the close-pulse length plus two clock cycles.
// R17 - Three-pole trip enable from cycle start until reset; kept on lockout.
// R18 - Lockout for other causes asserts three-pole trip enable throughout.
// R19 - Three-pole trip enable always on for three-pole program or source off.
// R20 - Outside relay uses inverted enable on a normally-closed contact.
// R21 - Cycle-active set at cycle start, cleared at reset or lockout.
// R22 - Lockout indication asserted throughout the lockout state.
// R23 - Settle interval after each close; fault restarts next delay or locks out.
// R24 - Source select chooses counted initiates: internal, external, both, none, off.
// R25 - One to four attempts, each own delay, timed from initiate.
// R26 - Close pulse length 0.1 to 2.0 s.
// R27 - Intervals counted by 100 ms ticks from the system clock.
module rcl_recloser
    import rcl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RCL_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    // Settings
    input wire logic [2:0] recloser_source_select,
    input wire logic [1:0] recloser_program_select,
    input wire logic trip_pole_select,
    input wire logic [2:0] attempt_count,
    input wire logic [3:0][`RCL_TENTHS_W-1:0] attempt_delay,
    input wire logic hold_enable,
    input wire logic hold_normally_closed,
    input wire logic [`RCL_SECS_W-1:0] supervision_wait_setting,
    input wire logic [`RCL_TENTHS_W-1:0] settle_interval_setting,
    input wire logic [4:0] close_pulse_length,
    // Internal initiates from protection logic on clk
    input wire logic single_pole_initiate_int,
    input wire logic three_pole_initiate_int,
    // Contact inputs (asynchronous)
    input wire logic breaker_open_3p,
    input wire logic breaker_open_a,
    input wire logic breaker_open_b,
    input wire logic breaker_open_c,
    input wire logic single_pole_initiate_ext,
    input wire logic three_pole_initiate_ext,
    input wire logic hold_in,
    input wire logic cancel_in,
    input wire logic lockout_in,
    input wire logic reset_in,
    // Outputs
    output logic close_out,
    output logic three_pole_trip_enable,
    output logic cycle_active_flag,
    output logic lockout_flag
);
    rcl_tick_if tb_if ();

    logic [`RCL_PIN_W-1:0] pin_meta_ff;
    logic [`RCL_PIN_W-1:0] pin_ff;
    logic [1:0] init_prev_ff;
    logic lockout_prev_ff;
    rcl_state_e state_ff;
    rcl_state_e nxt_state;
    rcl_timer_t timer_ff;
    rcl_timer_t nxt_timer;
    logic [1:0] attempt_ff;
    logic [1:0] nxt_attempt;
    logic cancel_pend_ff;
    logic close_ff;
    logic tpte_ff;
    logic active_ff;
    logic lock_ff;
    logic load;
    logic breaker_closed;
    logic permit;
    logic init_1p;
    logic init_3p;
    logic [1:0] init_lvl;
    logic [1:0] init_rise;
    logic any_init;
    logic tick_done;
    rcl_source_e src;
    rcl_program_e prog;

    if (TICK_CYCLES < 2) begin : g_chk
        $error("rcl_recloser: TICK_CYCLES must be at least 2");
    end

    rcl_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .clk(clk),
        .srst(srst),
        .tb(tb_if.src)
    );

    assign src = rcl_source_e'(recloser_source_select);
    assign prog = rcl_program_e'(recloser_program_select);

    // Two-stage synchroniser for every contact input
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_ff <= '0;
            pin_ff <= '0;
        end else begin
            pin_meta_ff <= {breaker_open_3p, breaker_open_a, breaker_open_b, breaker_open_c,
                single_pole_initiate_ext, three_pole_initiate_ext, hold_in, cancel_in,
                lockout_in, reset_in};
            pin_ff <= pin_meta_ff;
        end
    end

    // Breaker position from one or three auxiliary contacts
    always_comb begin
        if (trip_pole_select) begin
            breaker_closed = !(pin_ff[`RCL_PIN_OPEN_A] || pin_ff[`RCL_PIN_OPEN_B]
                || pin_ff[`RCL_PIN_OPEN_C]); // R01
        end else begin
            breaker_closed = !pin_ff[`RCL_PIN_OPEN_3P]; // R01
        end
    end

    // Hold permit state follows the contact type
    assign permit = hold_normally_closed ? pin_ff[`RCL_PIN_HOLD]
        : !pin_ff[`RCL_PIN_HOLD]; // R06

    // Initiate sources selected by mode; none and off count nothing
    always_comb begin
        init_1p = 1'b0;
        init_3p = 1'b0;
        unique case (src)
            RCL_SRC_INTERNAL: begin
                init_1p = single_pole_initiate_int;
                init_3p = three_pole_initiate_int;
            end
            RCL_SRC_EXTERNAL: begin
                init_1p = pin_ff[`RCL_PIN_EXT_1P]; // R02
                init_3p = pin_ff[`RCL_PIN_EXT_3P]; // R03
            end
            RCL_SRC_BOTH: begin
                init_1p = single_pole_initiate_int || pin_ff[`RCL_PIN_EXT_1P]; // R02
                init_3p = three_pole_initiate_int || pin_ff[`RCL_PIN_EXT_3P]; // R03
            end
            default: begin // R24
                init_1p = 1'b0;
                init_3p = 1'b0;
            end
        endcase
    end

    // Initiates act on assertion, not on a held level
    assign init_lvl = {init_1p, init_3p};
    assign init_rise = init_lvl & ~init_prev_ff;
    assign any_init = |init_rise;
    assign tick_done = (timer_ff == '0);

    always_ff @(posedge clk) begin
        if (srst) begin
            init_prev_ff <= 2'h0;
            lockout_prev_ff <= 1'b0;
        end else begin
            init_prev_ff <= init_lvl;
            lockout_prev_ff <= pin_ff[`RCL_PIN_LOCKOUT];
        end
    end

    // Sequencer next state, interval load and attempt index
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_attempt = attempt_ff;
        load = 1'b0;
        if (tb_if.tick && !tick_done) begin
            nxt_timer = timer_ff - `RCL_TIMER_W'(1); // R27
        end
        unique case (state_ff)
            RCL_ST_RESET: begin
                if (!pin_ff[`RCL_PIN_CANCEL] && any_init) begin // R09
                    nxt_attempt = 2'h0;
                    if ((init_rise[1] && prog != RCL_PROG_THREE)
                        || (init_rise[0] && prog != RCL_PROG_SINGLE)) begin // R02 R03
                        nxt_state = RCL_ST_DELAY;
                        nxt_timer = `RCL_TIMER_W'(attempt_delay[0]); // R25
                        load = 1'b1;
                    end else begin
                        nxt_state = RCL_ST_LOCKOUT;
                    end
                end
            end
            RCL_ST_DELAY: begin
                if (pin_ff[`RCL_PIN_CANCEL]) begin
                    nxt_state = RCL_ST_LOCKOUT; // R10
                end else if (tick_done) begin
                    load = 1'b1;
                    if (hold_enable && !permit) begin // R04 R07 R08
                        nxt_state = RCL_ST_HOLD;
                        nxt_timer = `RCL_TIMER_W'(supervision_wait_setting
                            * `RCL_TICKS_PER_SEC);
                    end else begin
                        nxt_state = RCL_ST_CLOSE;
                        nxt_timer = `RCL_TIMER_W'(close_pulse_length); // R16 R26
                    end
                end
            end
            RCL_ST_HOLD: begin
                if (pin_ff[`RCL_PIN_CANCEL]) begin
                    nxt_state = RCL_ST_LOCKOUT; // R10
                end else if (permit) begin // R04
                    nxt_state = RCL_ST_CLOSE;
                    nxt_timer = `RCL_TIMER_W'(close_pulse_length); // R16
                    load = 1'b1;
                end else if (tick_done) begin
                    nxt_state = RCL_ST_LOCKOUT; // R05
                end
            end
            RCL_ST_CLOSE: begin
                if (tick_done) begin
                    if (cancel_pend_ff || pin_ff[`RCL_PIN_CANCEL]) begin
                        nxt_state = RCL_ST_LOCKOUT; // R11
                    end else begin
                        nxt_state = RCL_ST_SETTLE;
                        nxt_timer = `RCL_TIMER_W'(settle_interval_setting); // R23
                        load = 1'b1;
                    end
                end
            end
            RCL_ST_SETTLE: begin
                if (pin_ff[`RCL_PIN_CANCEL]) begin
                    nxt_state = RCL_ST_LOCKOUT; // R10
                end else if (any_init) begin
                    if ({1'b0, attempt_ff} + 3'h1 < attempt_count) begin // R23 R25
                        nxt_attempt = attempt_ff + 2'h1;
                        nxt_state = RCL_ST_DELAY;
                        nxt_timer = `RCL_TIMER_W'(attempt_delay[attempt_ff + 2'h1]);
                        load = 1'b1;
                    end else begin
                        nxt_state = RCL_ST_LOCKOUT; // R23
                    end
                end else if (tick_done) begin
                    nxt_state = RCL_ST_RESET; // R23
                end
            end
            RCL_ST_LOCKOUT: begin
                // Cancel is not looked at here
                if (!pin_ff[`RCL_PIN_LOCKOUT] && breaker_closed
                    && (lockout_prev_ff || pin_ff[`RCL_PIN_RESET])) begin // R12 R14 R15
                    nxt_state = RCL_ST_RESET;
                end
            end
            default: begin
                nxt_state = RCL_ST_LOCKOUT;
            end
        endcase
        // Lockout input overrides everything, close pulse included
        if (pin_ff[`RCL_PIN_LOCKOUT]) begin
            nxt_state = RCL_ST_LOCKOUT; // R13
            load = 1'b0;
        end
    end

    assign tb_if.restart = load;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= RCL_ST_RESET;
            timer_ff <= '0;
            attempt_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            attempt_ff <= nxt_attempt;
        end
    end

    // Cancel seen during the close pulse is remembered until it ends
    always_ff @(posedge clk) begin
        if (srst || state_ff != RCL_ST_CLOSE) begin
            cancel_pend_ff <= 1'b0;
        end else if (pin_ff[`RCL_PIN_CANCEL]) begin
            cancel_pend_ff <= 1'b1; // R11
        end
    end

    // Outputs registered from the next state so they align with it
    always_ff @(posedge clk) begin
        if (srst) begin
            close_ff <= 1'b0;
            tpte_ff <= 1'b0;
            active_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            close_ff <= (nxt_state == RCL_ST_CLOSE); // R16
            active_ff <= (nxt_state != RCL_ST_RESET)
                && (nxt_state != RCL_ST_LOCKOUT); // R21
            lock_ff <= (nxt_state == RCL_ST_LOCKOUT); // R22
            tpte_ff <= (nxt_state != RCL_ST_RESET) // R17 R18
                || (prog == RCL_PROG_THREE) || (src == RCL_SRC_OFF); // R19
        end
    end

    // Enable is active high; an outside relay inverts it onto a closed-at-rest contact
    assign close_out = close_ff;
    assign three_pole_trip_enable = tpte_ff; // R20
    assign cycle_active_flag = active_ff;
    assign lockout_flag = lock_ff;
endmodule // rcl_recloser
`default_nettype wire

// ===== rcl_recloser_chk.sv
// Purpose: Port-level checks for the recloser sequencer.
// Assumes: clk rising edge, srst synchronous active high.
// Notes: Contact pins pass two sync flops, so checks on them allow lead cycles.
`default_nettype none
module rcl_recloser_chk #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] recloser_source_select,
    input wire logic trip_pole_select,
    input wire logic [4:0] close_pulse_length,
    input wire logic three_pole_initiate_int,
    input wire logic breaker_open_3p,
    input wire logic cancel_in,
    input wire logic lockout_in,
    input wire logic close_out,
    input wire logic three_pole_trip_enable,
    input wire logic cycle_active_flag,
    input wire logic lockout_flag
);
    int unsigned hi_cnt_ff;
    int unsigned pulse_lim;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Pulse length in clk cycles; the registered tick and the exit after the timer reaches zero add two
    assign pulse_lim = close_pulse_length * TICK_CYCLES + 2;

    // Cycles the close output has stood high so far
    always_ff @(posedge clk) begin
        if (srst || !close_out) begin
            hi_cnt_ff <= 0;
        end else begin
            hi_cnt_ff <= hi_cnt_ff + 1;
        end
    end

    AST_LOCK_TRIP: assert property (lockout_flag |-> three_pole_trip_enable)
        else $error("trip enable low in lockout");
    AST_LOCK_IN: assert property (lockout_in [*5] |-> lockout_flag)
        else $error("lockout input did not force lockout");
    AST_EXCL: assert property (!(cycle_active_flag && lockout_flag))
        else $error("cycle active and lockout together");
    AST_CYC_TRIP: assert property (cycle_active_flag |-> three_pole_trip_enable)
        else $error("trip enable low during cycle");
    AST_CLOSE_MAX: assert property (close_out |-> hi_cnt_ff < pulse_lim)
        else $error("close pulse too long");
    // Lockout input may cut the pulse short, so only clean ends are judged
    AST_CLOSE_LEN: assert property ($fell(close_out) && !lockout_flag |->
        hi_cnt_ff >= pulse_lim)
        else $error("close pulse too short");
    AST_OFF_TRIP: assert property (recloser_source_select == 3'h4 &&
        $stable(recloser_source_select) && !$past(srst) |-> three_pole_trip_enable)
        else $error("trip enable low with source off");
    AST_CANCEL_RST: assert property (cancel_in [*4] ##0 ($rose(three_pole_initiate_int) &&
        !cycle_active_flag && !lockout_flag) |=> !cycle_active_flag && !lockout_flag)
        else $error("initiate taken while cancel held");
    AST_LOCK_EXIT: assert property ($fell(lockout_flag) && !trip_pole_select |->
        !$past(breaker_open_3p, 3))
        else $error("lockout left with breaker open");

    COV_CLOSE: cover property ($rose(close_out));
    COV_LOCK: cover property ($rose(lockout_flag));
    COV_DONE: cover property ($fell(cycle_active_flag) && !lockout_flag);
endmodule // rcl_recloser_chk

bind rcl_recloser rcl_recloser_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .srst(srst), .recloser_source_select(recloser_source_select),
    .trip_pole_select(trip_pole_select), .close_pulse_length(close_pulse_length),
    .three_pole_initiate_int(three_pole_initiate_int), .breaker_open_3p(breaker_open_3p),
    .cancel_in(cancel_in), .lockout_in(lockout_in), .close_out(close_out),
    .three_pole_trip_enable(three_pole_trip_enable),
    .cycle_active_flag(cycle_active_flag), .lockout_flag(lockout_flag));
`default_nettype wire

// ===== rcl_breaker_model.sv
// Purpose: Breaker auxiliary contacts and outside relay contact.
// Assumes: Breaker closes on the close output, opens when the bench trips it.
// Notes: All poles move together; no pole discrepancy modelled.
`default_nettype none
module rcl_breaker_model (
    input wire logic clk,
    input wire logic close_out,
    input wire logic trip_req,
    input wire logic close_req,
    input wire logic trip_enable,
    output logic open_3p,
    output logic open_a,
    output logic open_b,
    output logic open_c,
    output logic nc_contact
);
    timeunit 1ns;
    timeprecision 100ps;
    logic open_ff = 1'b0;

    // Trip wins over close, as a trip coil would
    always @(posedge clk) begin
        if (trip_req) begin
            open_ff <= 1'b1;
        end else if (close_out || close_req) begin
            open_ff <= 1'b0;
        end
    end

    // One contact and three phase contacts show the same position
    assign open_3p = open_ff;
    assign open_a = open_ff;
    assign open_b = open_ff;
    assign open_c = open_ff;
    // Coil driven by the inverted enable; the form b contact closes when it drops
    wire logic nc_coil = !trip_enable;
    assign nc_contact = !nc_coil;
endmodule // rcl_breaker_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: Sequence tests of the recloser at its pins.
// Assumes: Tick shortened to 10 cycles; delays 2, settle 3, pulse 2, hold 10 ticks.
// Notes: Inputs move on the falling edge only.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, srst = 1, tp_int = 0, sp_int = 0, tp_ext = 0, sp_ext = 0;
    logic hold_en = 0, hold_nc = 1, hold_in = 0, cancel_in = 0, lockout_in = 0;
    logic reset_in = 0, trip_req = 0, close_req = 0, close_seen = 0, tps = 0;
    logic [2:0] src = 3'h1, att_cnt = 3'h2;
    logic [1:0] prog = 2'h2;
    logic [3:0][11:0] att_dly = {4{12'h002}};
    logic [9:0] hold_s = 10'h001;
    logic [11:0] settle = 12'h003;
    logic [4:0] pulse = 5'h02;
    logic close_out, trip_en, cyc, lock;
    wire logic op3, opa, opb, opc, nc_contact;
    int mismatches = 0, checks_done = 0;

    // 100 MHz clock
    initial begin
        forever #5 clk = !clk;
    end

    rcl_recloser #(.TICK_CYCLES(10)) uut (.clk(clk), .srst(srst),
        .recloser_source_select(src), .recloser_program_select(prog),
        .trip_pole_select(tps), .attempt_count(att_cnt), .attempt_delay(att_dly),
        .hold_enable(hold_en), .hold_normally_closed(hold_nc),
        .supervision_wait_setting(hold_s), .settle_interval_setting(settle),
        .close_pulse_length(pulse), .single_pole_initiate_int(sp_int),
        .three_pole_initiate_int(tp_int), .breaker_open_3p(op3), .breaker_open_a(opa),
        .breaker_open_b(opb), .breaker_open_c(opc), .single_pole_initiate_ext(sp_ext),
        .three_pole_initiate_ext(tp_ext), .hold_in(hold_in), .cancel_in(cancel_in),
        .lockout_in(lockout_in), .reset_in(reset_in), .close_out(close_out),
        .three_pole_trip_enable(trip_en), .cycle_active_flag(cyc), .lockout_flag(lock));
    rcl_breaker_model u_brk (.clk(clk), .close_out(close_out), .trip_req(trip_req),
        .close_req(close_req), .trip_enable(trip_en), .open_3p(op3), .open_a(opa),
        .open_b(opb), .open_c(opc), .nc_contact(nc_contact));

    // Remember any close pulse, for attempts that must not close
    always @(posedge clk) begin
        if (close_out === 1'b1) close_seen <= 1'b1;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic go(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait: 0 close, 1 cycle active, 2 lockout
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        logic v;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            v = (sel == 0) ? close_out : (sel == 1) ? cyc : lock;
            if (v === lvl) return;
        end
        mismatches++;
        $display("unexpected timeout on output %0d: expected %b", sel, lvl);
        report_and_stop();
    endtask

    // Trip the breaker and raise one initiate: 0 three-pole, 1 single-pole, 2 external
    task automatic fire(input int which);
        @(negedge clk);
        trip_req = 1;
        if (which == 2) tp_ext = 1;
        else if (which == 1) sp_int = 1;
        else tp_int = 1;
        go(which == 2 ? 4 : 1);
        {trip_req, tp_ext, sp_int, tp_int} = 4'h0;
    endtask

    // Close the breaker by hand, then leave lockout with the reset input
    task automatic clear_lock();
        close_req = 1;
        go(2);
        close_req = 0;
        reset_in = 1;
        go(4);
        reset_in = 0;
        wait_for(2, 0, 10);
    endtask

    initial begin
        go(6);
        srst = 0;
        go(3);
        fire(0);
        go(2);
        check("cycle_active", cyc, 1);
        check("trip_enable", trip_en, 1);
        wait_for(0, 1, 60);
        go(19);
        check("close_high", close_out, 1);
        go(3);
        check("close_low", close_out, 0);
        go(5);
        fire(0);
        wait_for(0, 1, 60);
        wait_for(0, 0, 30);
        go(5);
        fire(0);
        wait_for(2, 1, 10);
        check("cyc_in_lock", cyc, 0);
        check("trip_in_lock", trip_en, 1);
        clear_lock();
        $display("attempts test done");
        fire(1);
        wait_for(0, 1, 60);
        wait_for(0, 0, 30);
        wait_for(1, 0, 60);
        check("trip_after_ok", trip_en, 0);
        check("lock_after_ok", lock, 0);
        check("nc_open", nc_contact, 0);
        $display("single pole test done");
        fire(0);
        wait_for(0, 1, 60);
        cancel_in = 1;
        wait_for(0, 0, 30);
        check("lock_at_pulse_end", lock, 1);
        clear_lock();
        cancel_in = 1;
        go(4);
        fire(0);
        go(6);
        check("cyc_cancel", cyc, 0);
        check("lock_cancel", lock, 0);
        cancel_in = 0;
        go(4);
        fire(0);
        go(3);
        cancel_in = 1;
        wait_for(2, 1, 10);
        go(10);
        check("lock_cancel_held", lock, 1);
        cancel_in = 0;
        reset_in = 1;
        go(6);
        reset_in = 0;
        check("reset_open", lock, 1);
        lockout_in = 1;
        go(4);
        lockout_in = 0;
        go(6);
        check("release_open", lock, 1);
        close_req = 1;
        lockout_in = 1;
        go(5);
        close_req = 0;
        check("lock_forced", lock, 1);
        check("lock_trip", trip_en, 1);
        check("nc_closed", nc_contact, 1);
        lockout_in = 0;
        wait_for(2, 0, 10);
        $display("cancel and lockout test done");
        {tps, hold_en, hold_nc, hold_in, close_seen} = 5'h1c;
        fire(0);
        wait_for(2, 1, 150);
        check("no_close_hold", close_seen, 0);
        clear_lock();
        hold_in = 1;
        go(4);
        fire(0);
        wait_for(0, 1, 40);
        wait_for(0, 0, 30);
        hold_nc = 0;
        go(3);
        close_seen = 0;
        fire(0);
        wait_for(2, 1, 150);
        check("no_close_second", close_seen, 0);
        clear_lock();
        hold_en = 0;
        $display("hold test done");
        src = 3'h4;
        go(3);
        check("trip_off", trip_en, 1);
        fire(0);
        go(6);
        check("cyc_off", cyc, 0);
        src = 3'h0;
        go(3);
        check("trip_none", trip_en, 0);
        src = 3'h2;
        fire(0);
        go(6);
        check("cyc_ext_int", cyc, 0);
        fire(2);
        go(4);
        check("cyc_ext", cyc, 1);
        $display("source test done");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
